// ==== srws_defs.svh ====
`ifndef SRWS_DEFS_SVH
`define SRWS_DEFS_SVH
// =====================================================
// timing
// =====================================================
`define SRWS_CLK_HZ 10000000
`define SRWS_RELEASE_MS 200
`define SRWS_POWERUP_MS 250
`define SRWS_WDT0_MS 1400
`define SRWS_WDT1_MS 600
`define SRWS_WDT2_MS 200
// =====================================================
// watchdog select codes and reset value
// =====================================================
`define SRWS_WD_SEL_T0 2'h0
`define SRWS_WD_SEL_T1 2'h1
`define SRWS_WD_SEL_T2 2'h2
`define SRWS_WD_SEL_OFF 2'h3
`define SRWS_WD_SEL_RESET 2'h3
`endif

// ==== srws_pkg.sv ====
package srws_pkg;
   typedef enum logic [1:0] {srws_st_hold, srws_st_count, srws_st_run} srws_state_e;
   typedef logic [1:0] srws_wdsel_t;
endpackage

// ==== srws_bus_if.sv ====
interface srws_bus_if;
   logic restart;
   logic bus_abort;
   modport mon (output restart, input bus_abort);
   modport ctl (input restart, output bus_abort);
endinterface

// ==== srws_bus_mon.sv ====
`include "srws_defs.svh"
module srws_bus_mon
   import srws_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic data_in,
   input wire logic clk_in,
   srws_bus_if.mon bus
);
   typedef struct packed {
      logic [2:0] sda_sync;
      logic [2:0] scl_sync;
      logic sda_q;
      logic in_frame;
      logic seen_low;
      logic seen_high;
      logic restart;
   } srws_mon_s;
   srws_mon_s st, next_st;
   logic sda_ok, scl_ok, start_ev, stop_ev;
   always_comb begin
      next_st = st;
      next_st.sda_sync = {st.sda_sync[1:0], data_in};
      next_st.scl_sync = {st.scl_sync[1:0], clk_in};
      sda_ok = (st.sda_sync[2] == st.sda_sync[1]);
      scl_ok = (st.scl_sync[2] == st.scl_sync[1]);
      start_ev = 1'b0;
      stop_ev = 1'b0;
      next_st.restart = 1'b0;
      if (sda_ok) begin
         next_st.sda_q = st.sda_sync[1];
         if (scl_ok && st.scl_sync[1] && st.sda_q && !st.sda_sync[1]) begin
            start_ev = 1'b1;
         end
         if (scl_ok && st.scl_sync[1] && !st.sda_q && st.sda_sync[1]) begin
            stop_ev = 1'b1;
         end
      end
      if (bus.bus_abort) begin
         next_st.in_frame = 1'b0;
      end else if (start_ev) begin
         next_st.in_frame = 1'b1;
         next_st.seen_low = 1'b0;
         next_st.seen_high = 1'b0;
      end else if (stop_ev) begin
         next_st.in_frame = 1'b0;
         next_st.restart = st.in_frame && st.seen_low && st.seen_high;
      end else if (st.in_frame && scl_ok) begin
         if (!st.scl_sync[1]) begin
            next_st.seen_low = 1'b1;
         end else if (st.seen_low) begin
            next_st.seen_high = 1'b1;
         end
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{sda_sync: 3'h7, scl_sync: 3'h7, sda_q: 1'b1, default: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign bus.restart = st.restart;
endmodule

// ==== srws_supervisor.sv ====
`include "srws_defs.svh"
module srws_supervisor
   import srws_pkg::*;
#(
   parameter int CLK_HZ = `SRWS_CLK_HZ,
   parameter int RELEASE_MS = `SRWS_POWERUP_MS,
   parameter int RELEASE_CYC = (CLK_HZ / 1000) * RELEASE_MS,
   parameter int WDT0_CYC = (CLK_HZ / 1000) * `SRWS_WDT0_MS,
   parameter int WDT1_CYC = (CLK_HZ / 1000) * `SRWS_WDT1_MS,
   parameter int WDT2_CYC = (CLK_HZ / 1000) * `SRWS_WDT2_MS,
   parameter bit ACTIVE_HIGH = 1'b0
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic supply_low,
   input wire logic data_in,
   input wire logic clk_in,
   input wire logic write_prot,
   input wire logic sel_we,
   input wire srws_pkg::srws_wdsel_t sel_wdata,
   input wire srws_pkg::srws_wdsel_t sel_stored,
   output logic rst_out,
   output logic rst_oe,
   output logic sel_commit,
   output srws_pkg::srws_wdsel_t wd_sel,
   output logic bus_abort,
   output logic nv_start_ok
);
   import srws_pkg::*;
   localparam int CW = 32;
   typedef struct packed {
      logic [2:0] low_sync;
      srws_state_e state;
      logic [CW-1:0] rel_cnt;
      logic [CW-1:0] wd_cnt;
      srws_wdsel_t sel;
      logic loaded;
      logic rst_act;
      logic rst_out;
      logic rst_oe;
      logic commit;
      logic abort;
      logic nv_ok;
   } srws_top_s;
   srws_top_s st, next_st;
   srws_bus_if bus_i();
   logic low_ok, low, wd_fire;
   logic [CW-1:0] wd_limit;
   function automatic logic [CW-1:0] wd_period(input srws_wdsel_t s);
      case (s)
         `SRWS_WD_SEL_T0: wd_period = WDT0_CYC[CW-1:0];
         `SRWS_WD_SEL_T1: wd_period = WDT1_CYC[CW-1:0];
         `SRWS_WD_SEL_T2: wd_period = WDT2_CYC[CW-1:0];
         default: wd_period = '0;
      endcase
   endfunction
   srws_bus_mon u_mon (
      .clock(clock),
      .arst_n(arst_n),
      .data_in(data_in),
      .clk_in(clk_in),
      .bus(bus_i.mon)
   );
   assign bus_i.bus_abort = st.abort;
   // =====================================================
   // supervision and watchdog
   // =====================================================
   always_comb begin
      next_st = st;
      next_st.low_sync = {st.low_sync[1:0], supply_low};
      low_ok = (st.low_sync[2] == st.low_sync[1]);
      low = st.low_sync[2];
      wd_limit = wd_period(st.sel);
      wd_fire = 1'b0;
      next_st.commit = 1'b0;
      if (!st.loaded) begin
         next_st.sel = sel_stored;
         next_st.loaded = 1'b1;
      end else if (sel_we && !write_prot && !low) begin
         next_st.sel = sel_wdata;
         next_st.commit = 1'b1;
      end
      case (st.state)
         srws_st_hold: begin
            next_st.rel_cnt = '0;
            if (low_ok && !low) begin
               next_st.state = srws_st_count;
            end
         end
         srws_st_count: begin
            if (low) begin
               next_st.state = srws_st_hold;
               next_st.rel_cnt = '0;
            end else if (st.rel_cnt >= RELEASE_CYC[CW-1:0] - 1) begin
               next_st.state = srws_st_run;
            end else begin
               next_st.rel_cnt = st.rel_cnt + 1'b1;
            end
         end
         srws_st_run: begin
            if (low) begin
               next_st.state = srws_st_hold;
            end
         end
         default: next_st.state = srws_st_hold;
      endcase
      if (st.state != srws_st_run || st.sel == `SRWS_WD_SEL_OFF || bus_i.restart) begin
         next_st.wd_cnt = '0;
      end else if (st.wd_cnt >= wd_limit - 1) begin
         wd_fire = 1'b1;
         next_st.wd_cnt = '0;
      end else begin
         next_st.wd_cnt = st.wd_cnt + 1'b1;
      end
      if (wd_fire) begin
         next_st.state = srws_st_hold;
      end
      next_st.rst_act = (next_st.state != srws_st_run);
      // open drain: only ever pulls low, the pull-up gives the high level
      next_st.rst_out = 1'b0;
      next_st.rst_oe = ACTIVE_HIGH ? !next_st.rst_act : next_st.rst_act;
      next_st.abort = low;
      next_st.nv_ok = !low && !write_prot;
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{low_sync: 3'h7, state: srws_st_hold, rel_cnt: '0, wd_cnt: '0,
            sel: `SRWS_WD_SEL_RESET, loaded: 1'b0, rst_act: 1'b1, rst_out: 1'b0,
            rst_oe: !ACTIVE_HIGH, commit: 1'b0, abort: 1'b1, nv_ok: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign rst_out = st.rst_out;
   assign rst_oe = st.rst_oe;
   assign sel_commit = st.commit;
   assign wd_sel = st.sel;
   assign bus_abort = st.abort;
   assign nv_start_ok = st.nv_ok;
endmodule

// ==== srws_supervisor_properties.sv ====
module srws_supervisor_properties
   import srws_pkg::*;
#(
   parameter int RELEASE_CYC = 20
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic supply_low,
   input wire logic rst_oe,
   input wire srws_pkg::srws_wdsel_t wd_sel,
   input wire logic bus_abort
);
   timeunit 1ns;
   timeprecision 1ns;
   int good;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ==========
   // cycles since supply last seen low
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         good <= 0;
      end else begin
         good <= supply_low ? 0 : good + 1;
      end
   end
   property p_trip; supply_low [*8] |-> rst_oe; endproperty
   a_trip: assert property (p_trip) else $error("no trip");
   property p_rel; $fell(rst_oe) |-> good >= RELEASE_CYC; endproperty
   a_rel: assert property (p_rel) else $error("early release");
   property p_late; good == RELEASE_CYC + 10 |-> !rst_oe; endproperty
   a_late: assert property (p_late) else $error("late release");
   property p_hold; $rose(rst_oe) |=> rst_oe [*8]; endproperty
   a_hold: assert property (p_hold) else $error("short reset");
   property p_abort; supply_low [*8] |-> bus_abort; endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_clear; !supply_low [*8] |-> !bus_abort; endproperty
   a_clear: assert property (p_clear) else $error("abort stuck");
   property p_quiet; bus_abort |-> rst_oe; endproperty
   a_quiet: assert property (p_quiet) else $error("abort out of reset");
   property p_off; $rose(rst_oe) && wd_sel == 2'h3 |-> good < 8; endproperty
   a_off: assert property (p_off) else $error("watchdog off fired");
   c_rel: cover property ($fell(rst_oe));
   c_low: cover property ($rose(bus_abort));
   c_wd: cover property ($rose(rst_oe) && good > 8);
endmodule
bind srws_supervisor srws_supervisor_properties #(.RELEASE_CYC(RELEASE_CYC)) srws_supervisor_properties_i (
   .clock(clock), .arst_n(arst_n), .supply_low(supply_low), .rst_oe(rst_oe), .wd_sel(wd_sel),
   .bus_abort(bus_abort));

// ==== srws_host.sv ====
module srws_host (
   input wire logic clock,
   output logic sda,
   output logic scl
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // pulled-up lines idle high
   initial begin
      sda = 1'h1;
      scl = 1'h1;
   end
   task automatic step(input logic d, input logic c, input int n);
      @(negedge clock);
      sda = d;
      scl = c;
      repeat (n) @(negedge clock);
   endtask
   // start, clock low, clock high, stop
   task automatic restart(input int n);
      step(1'h0, 1'h1, n);
      step(1'h0, 1'h0, n);
      step(1'h0, 1'h1, n);
      step(1'h1, 1'h1, n);
   endtask
endmodule

// ==== supply_reset_watchdog_supervisor_tb.sv ====
module supply_reset_watchdog_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import srws_pkg::*;
   localparam int RC = 20;
   localparam int WD[3] = '{70, 55, 40};
   logic clock = 1'h0, arst_n = 1'h0, supply_low = 1'h1, write_prot = 1'h0, sel_we = 1'h0, last = 1'h0;
   logic data_in, clk_in, rst_out, rst_oe, sel_commit, bus_abort, nv_ok;
   srws_wdsel_t sel_wdata = 2'h0, wd_sel;
   logic [19:0] cyc = 20'h0;
   logic [40:0] q[$], e;
   int fail_count = 0, compares = 0;
   wire logic pin = rst_oe ? rst_out : 1'h1;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t %h %h", $time, a, b); end end
   srws_supervisor #(.RELEASE_CYC(RC), .WDT0_CYC(WD[0]), .WDT1_CYC(WD[1]), .WDT2_CYC(WD[2])) srws_supervisor_i (
      .clock(clock), .arst_n(arst_n), .supply_low(supply_low), .data_in(data_in), .clk_in(clk_in),
      .write_prot(write_prot), .sel_we(sel_we), .sel_wdata(sel_wdata), .sel_stored(2'h3), .rst_out(rst_out),
      .rst_oe(rst_oe), .sel_commit(sel_commit), .wd_sel(wd_sel), .bus_abort(bus_abort), .nv_start_ok(nv_ok));
   srws_host srws_host_i (.clock(clock), .sda(data_in), .scl(clk_in));
   always #50 clock = ~clock;
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic nt(input logic lv, input int lo, input int hi);
      q.push_back({lv, cyc + 20'(lo), cyc + 20'(hi)});
   endtask
   task automatic await();
      for (int i = 0; i < 400 && q.size() > 0; i++) @(negedge clock);
      if (q.size() > 0) begin
         fail_count++;
         end_of_test();
      end
   endtask
   task automatic sel(input srws_wdsel_t v, input logic wp);
      write_prot = wp;
      sel_wdata = v;
      sel_we = 1'h1;
      @(negedge clock);
      sel_we = 1'h0;
      `CHK(sel_commit, !wp)
      repeat (2) @(negedge clock);
   endtask
   // ==========
   // each change of the reset pin against the oldest note
   always @(negedge clock) begin
      cyc <= cyc + 20'h1;
      if (arst_n && pin !== last) begin
         last = pin;
         e = q.size() > 0 ? q.pop_front() : {~pin, 40'h0};
         `CHK(pin, e[40])
         `CHK(cyc >= e[39:20] && cyc <= e[19:0], 1'h1)
      end
   end
   initial begin
      void'($urandom(32'h1f46d3d1));
      repeat (5) @(negedge clock);
      arst_n = 1'h1;
      repeat (9) @(negedge clock);
      nt(1'h1, RC, RC + 9);
      supply_low = 1'h0;
      await();
      `CHK(bus_abort, 1'h0)
      `CHK(nv_ok, 1'h1)
      nt(1'h0, 1, 8);
      supply_low = 1'h1;
      await();
      @(negedge clock);
      `CHK(bus_abort, 1'h1)
      `CHK(nv_ok, 1'h0)
      supply_low = 1'h0;
      repeat (RC / 2) @(negedge clock);
      supply_low = 1'h1;
      repeat (4) @(negedge clock);
      nt(1'h1, RC, RC + 9);
      supply_low = 1'h0;
      await();
      sel(2'h1, 1'h1);
      `CHK(wd_sel, 2'h3)
      for (int s = 0; s < 3; s++) begin
         sel(2'(s), 1'h0);
         `CHK(wd_sel, 2'(s))
         repeat (3) srws_host_i.restart(2 + $urandom_range(2));
         nt(1'h0, WD[s] - 4, WD[s] + 8);
         await();
         nt(1'h1, RC - 2, RC + 9);
         await();
      end
      sel(2'h3, 1'h0);
      repeat (99) @(negedge clock);
      end_of_test();
   end
endmodule
